/* pkg/uopc_defines.vh */
// constants for the utopia output port configuration register bank
`ifndef UOPC_DEFINES_VH
`define UOPC_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define UOPC_OFS_ADDR_BASE 11'h000
`define UOPC_OFS_ADDR_LAST 11'h007
`define UOPC_OFS_LINK_EN 11'h010
`define UOPC_OFS_CTRL 11'h011
`define UOPC_OFS_USER 11'h012

// ----------------------------------------
// field positions and masks
// ----------------------------------------
`define UOPC_ADDR_LO_MSB 4
`define UOPC_ADDR_LO_LSB 0
`define UOPC_ADDR_HI_MSB 12
`define UOPC_ADDR_HI_LSB 8
`define UOPC_ADDR_MASK 16'h1F1F
`define UOPC_CTRL_MASK 16'h7FFF
`define UOPC_CTRL_BIT_8BIT 11
`define UOPC_CTRL_BIT_RXRST 9
`define UOPC_USER_MASK 16'h0FFF
`define UOPC_USER_MSB 7
`define UOPC_USER_LSB 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define UOPC_RST_WORD 16'h0000
`define UOPC_RST_ADDR 5'h00
`define UOPC_RST_BYTE 8'h00
`define UOPC_RST_LINK 4'h0
`define UOPC_RST_SYNC 2'h0
`define UOPC_RST_STRB 3'h7

`endif

/* core/uopc_addr_match.v */
// phy address comparator over all enabled links
`timescale 1ns/100ps

module uopc_addr_match #(
	parameter NUM_LINKS = 16,
	parameter AW = 5,
	parameter LW = 4
) (
	// configuration
	input wire [NUM_LINKS*AW-1:0] link_addr_in,
	input wire [NUM_LINKS-1:0] link_en_in,
	// presented address
	input wire [AW-1:0] phy_addr_in,
	// result
	output reg hit_out,
	output reg [LW-1:0] link_out
);

	wire [NUM_LINKS-1:0] hit_vec;

	// pick one link address out of the packed vector
	function [AW-1:0] uopc_slot;
		input [NUM_LINKS*AW-1:0] vec;
		input integer idx;
		begin
			uopc_slot = vec[idx*AW +: AW];
		end
	endfunction

	// a link answers only when enabled and its address matches
	genvar gi;
	generate
		for (gi = 0; gi < NUM_LINKS; gi = gi + 1) begin : g_cmp
			assign hit_vec[gi] = link_en_in[gi] && (uopc_slot(link_addr_in, gi) == phy_addr_in);
		end
	endgenerate

	// lowest numbered hit wins when software configured duplicates
	integer i;
	always @* begin
		hit_out = 1'b0;
		link_out = {LW{1'b0}};
		for (i = NUM_LINKS - 1; i >= 0; i = i - 1) begin
			if (hit_vec[i]) begin
				hit_out = 1'b1;
				link_out = i[LW-1:0];
			end
		end
	end

endmodule

/* core/uopc_regs.v */
// utopia output port configuration registers and phy address decode
`timescale 1ns/100ps
`include "uopc_defines.vh"

// Summary of operation
// - eight registers each hold the 5-bit phy address of link n in 4:0 and of link n+8 in 12:8.
// - bits 15:13 and 7:5 of every link address register read as zero.
// - one 16-bit register holds a per-link enable, bit n enabling the address of link n.
// - control bit 11 set selects an 8-bit receive bus, cleared selects 16-bit.
// - while control bit 9 is one the receive state machines are held in reset.
// - after reset all address, enable, control and user byte registers are zero.
// - in 16-bit mode the user byte in bits 7:0 is inserted as the sixth header byte.
module uopc_regs #(
	parameter DW = 16,
	parameter ABW = 11,
	parameter NUM_LINKS = 16,
	parameter PAW = 5
) (
	// clock, reset and enable
	input wire core_clk_in,
	input wire rstn_in,
	input wire ce_in,
	// microprocessor port, asynchronous to the core clock
	input wire cs_n_in,
	input wire wr_n_in,
	input wire rd_n_in,
	input wire [ABW-1:0] addr_in,
	input wire [DW-1:0] wdata_in,
	output reg [DW-1:0] rdata_out,
	// utopia address presented by the atm layer
	input wire [PAW-1:0] phy_addr_in,
	output reg addr_hit_out,
	output reg [3:0] addr_link_out,
	// configuration seen by the utopia logic
	output reg [NUM_LINKS*PAW-1:0] link_addr_out,
	output reg [NUM_LINKS-1:0] link_en_out,
	output reg bus_8bit_out,
	output reg rx_sm_reset_out,
	output reg [7:0] header_byte6_out,
	output reg header_byte6_valid_out
);

	localparam NPAIR = NUM_LINKS / 2;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	reg [1:0] rst_sync_reg;
	wire rst_n;

	// asynchronous assert, two-flop release
	always @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_sync_reg <= `UOPC_RST_SYNC;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	reg [2:0] strb_s1_reg;
	reg [2:0] strb_s2_reg;
	reg [ABW-1:0] addr_s1_reg;
	reg [ABW-1:0] addr_s2_reg;
	reg [DW-1:0] data_s1_reg;
	reg [DW-1:0] data_s2_reg;
	reg [PAW-1:0] phy_s1_reg;
	reg [PAW-1:0] phy_s2_reg;
	reg wr_prev_reg;
	reg wr_old_reg;
	wire wr_active;
	wire rd_active;
	wire wr_pulse;

	// every microprocessor and phy address pin passes two flops before the logic reads it; ce_in is read directly
	always @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			strb_s1_reg <= `UOPC_RST_STRB;
			strb_s2_reg <= `UOPC_RST_STRB;
			addr_s1_reg <= {ABW{1'b0}};
			addr_s2_reg <= {ABW{1'b0}};
			data_s1_reg <= `UOPC_RST_WORD;
			data_s2_reg <= `UOPC_RST_WORD;
			phy_s1_reg <= `UOPC_RST_ADDR;
			phy_s2_reg <= `UOPC_RST_ADDR;
			wr_prev_reg <= 1'b0;
			wr_old_reg <= 1'b0;
		end else if (ce_in) begin
			strb_s1_reg <= {cs_n_in, wr_n_in, rd_n_in};
			strb_s2_reg <= strb_s1_reg;
			addr_s1_reg <= addr_in;
			addr_s2_reg <= addr_s1_reg;
			data_s1_reg <= wdata_in;
			data_s2_reg <= data_s1_reg;
			phy_s1_reg <= phy_addr_in;
			phy_s2_reg <= phy_s1_reg;
			wr_prev_reg <= wr_active;
			wr_old_reg <= wr_prev_reg;
		end
	end

	// the write is taken one cycle after the synced strobe is seen, so the
	// separately synced address and data words have settled by then
	assign wr_active = !strb_s2_reg[2] && !strb_s2_reg[1];
	assign rd_active = !strb_s2_reg[2] && !strb_s2_reg[0];
	assign wr_pulse = wr_prev_reg && !wr_old_reg; // one write per strobe

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	reg [DW-1:0] addr_pair_reg [0:NPAIR-1];
	reg [NUM_LINKS-1:0] link_en_reg;
	reg [DW-1:0] ctrl_reg;
	reg [DW-1:0] user_reg;

	// one when the offset hits any pair register, zero otherwise
	function pair_sel;
		input [ABW-1:0] a;
		begin
			pair_sel = (a >= `UOPC_OFS_ADDR_BASE) && (a <= `UOPC_OFS_ADDR_LAST);
		end
	endfunction

	wire [2:0] pair_idx;
	assign pair_idx = addr_s2_reg[2:0];

	// address pair registers, only the two 5-bit fields are stored
	integer k;
	always @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			for (k = 0; k < NPAIR; k = k + 1) begin
				addr_pair_reg[k] <= `UOPC_RST_WORD;
			end
		end else if (ce_in && wr_pulse && pair_sel(addr_s2_reg)) begin
			addr_pair_reg[pair_idx] <= data_s2_reg & `UOPC_ADDR_MASK;
		end
	end

	// enable, control and user byte registers
	always @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			link_en_reg <= {NUM_LINKS{1'b0}};
			ctrl_reg <= `UOPC_RST_WORD;
			user_reg <= `UOPC_RST_WORD;
		end else if (ce_in && wr_pulse) begin
			case (addr_s2_reg)
				`UOPC_OFS_LINK_EN: begin
					link_en_reg <= data_s2_reg[NUM_LINKS-1:0];
				end
				`UOPC_OFS_CTRL: begin
					ctrl_reg <= data_s2_reg & `UOPC_CTRL_MASK; // bit 15 read-only
				end
				`UOPC_OFS_USER: begin
					user_reg <= data_s2_reg & `UOPC_USER_MASK;
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	reg [DW-1:0] rd_next;

	// unmapped offsets read as zero
	always @* begin
		rd_next = `UOPC_RST_WORD;
		if (pair_sel(addr_s2_reg)) begin
			rd_next = addr_pair_reg[pair_idx];
		end else begin
			case (addr_s2_reg)
				`UOPC_OFS_LINK_EN: rd_next = link_en_reg;
				`UOPC_OFS_CTRL: rd_next = ctrl_reg;
				`UOPC_OFS_USER: rd_next = user_reg;
				default: rd_next = `UOPC_RST_WORD;
			endcase
		end
	end

	// read data captured while the read strobe is active
	always @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			rdata_out <= `UOPC_RST_WORD;
		end else if (ce_in && rd_active) begin
			rdata_out <= rd_next;
		end
	end

	// ----------------------------------------
	// address decode toward the utopia bus
	// ----------------------------------------
	wire [NUM_LINKS*PAW-1:0] link_addr_flat;
	wire match_hit;
	wire [3:0] match_link;

	// link n sits low in pair n, link n+8 high in pair n
	genvar gp;
	generate
		for (gp = 0; gp < NPAIR; gp = gp + 1) begin : g_unpack
			assign link_addr_flat[gp*PAW +: PAW] =
				addr_pair_reg[gp][`UOPC_ADDR_LO_MSB:`UOPC_ADDR_LO_LSB];
			assign link_addr_flat[(gp+NPAIR)*PAW +: PAW] =
				addr_pair_reg[gp][`UOPC_ADDR_HI_MSB:`UOPC_ADDR_HI_LSB];
		end
	endgenerate

	uopc_addr_match #(
		.NUM_LINKS(NUM_LINKS),
		.AW(PAW),
		.LW(4)
	) u_match (
		.link_addr_in(link_addr_flat),
		.link_en_in(link_en_reg),
		.phy_addr_in(phy_s2_reg),
		.hit_out(match_hit),
		.link_out(match_link)
	);

	// ----------------------------------------
	// registered configuration outputs
	// ----------------------------------------
	always @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			addr_hit_out <= 1'b0;
			addr_link_out <= `UOPC_RST_LINK;
			link_addr_out <= {NUM_LINKS*PAW{1'b0}};
			link_en_out <= {NUM_LINKS{1'b0}};
			bus_8bit_out <= 1'b0;
			rx_sm_reset_out <= 1'b0;
			header_byte6_out <= `UOPC_RST_BYTE;
			header_byte6_valid_out <= 1'b0;
		end else if (ce_in) begin
			// no answer while the receive machines are held in reset
			addr_hit_out <= match_hit && !ctrl_reg[`UOPC_CTRL_BIT_RXRST];
			addr_link_out <= match_link;
			link_addr_out <= link_addr_flat;
			link_en_out <= link_en_reg;
			bus_8bit_out <= ctrl_reg[`UOPC_CTRL_BIT_8BIT];
			rx_sm_reset_out <= ctrl_reg[`UOPC_CTRL_BIT_RXRST];
			header_byte6_out <= user_reg[`UOPC_USER_MSB:`UOPC_USER_LSB];
			header_byte6_valid_out <= !ctrl_reg[`UOPC_CTRL_BIT_8BIT];
		end
	end

endmodule

/* verification/uopc_regs_sva.sv */
// concurrent checks on the ports of the output port configuration bank
`timescale 1ns/100ps
module uopc_regs_chk (
	// clock and reset
	input wire core_clk_in,
	input wire rstn_in,
	input wire ce_in,
	// register port
	input wire cs_n_in,
	input wire wr_n_in,
	input wire rd_n_in,
	input wire [10:0] addr_in,
	input wire [15:0] wdata_in,
	input wire [15:0] rdata_out,
	// address decode and configuration
	input wire [4:0] phy_addr_in,
	input wire addr_hit_out,
	input wire [3:0] addr_link_out,
	input wire [79:0] link_addr_out,
	input wire [15:0] link_en_out,
	input wire bus_8bit_out,
	input wire rx_sm_reset_out,
	input wire [7:0] header_byte6_out,
	input wire header_byte6_valid_out
);
	reg [2:0] up_reg;
	// edges since reset release, so checks skip the reset sync flops
	always @(posedge core_clk_in or negedge rstn_in) begin
		if (!rstn_in) up_reg <= 3'h0;
		else if (up_reg != 3'h4) up_reg <= up_reg + 3'h1;
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);
	a_reset_clears_all: assert property (disable iff (1'b0) !rstn_in |-> link_en_out == 16'h0000 &&
		link_addr_out == 80'h0 && !bus_8bit_out && !rx_sm_reset_out && header_byte6_out == 8'h00 &&
		!addr_hit_out && rdata_out == 16'h0000)
		else $error("outputs not cleared in reset");
	a_addr_write_lands: assert property (up_reg == 3'h4 && ce_in && $fell(cs_n_in | wr_n_in) && addr_in < 11'h008 |->
		##[1:6] link_addr_out[addr_in[2:0]*5 +: 5] == wdata_in[4:0] &&
		link_addr_out[(addr_in[2:0]+8)*5 +: 5] == wdata_in[12:8])
		else $error("link address write not applied");
	a_ctrl_write_lands: assert property (up_reg == 3'h4 && ce_in && $fell(cs_n_in | wr_n_in) && addr_in == 11'h011 |->
		##[1:6] bus_8bit_out == wdata_in[11] && rx_sm_reset_out == wdata_in[9])
		else $error("control write not applied");
	a_user_write_lands: assert property (up_reg == 3'h4 && ce_in && $fell(cs_n_in | wr_n_in) && addr_in == 11'h012 |->
		##[1:6] header_byte6_out == wdata_in[7:0])
		else $error("user byte write not applied");
	a_byte6_in_wide: assert property (up_reg == 3'h4 && $stable(bus_8bit_out) |->
		header_byte6_valid_out == !bus_8bit_out)
		else $error("header byte valid disagrees with bus width");
	a_hit_matches: assert property (addr_hit_out && $past(phy_addr_in, 3) == $past(phy_addr_in, 2) &&
		$past(link_en_out, 3) == link_en_out && $past(link_addr_out, 3) == link_addr_out |->
		link_en_out[addr_link_out] && link_addr_out[addr_link_out*5 +: 5] == $past(phy_addr_in, 3))
		else $error("hit on a disabled or unmatched link");
	a_rxrst_blocks_hit: assert property (rx_sm_reset_out && $past(rx_sm_reset_out, 2) |-> !addr_hit_out)
		else $error("address answered while receive side in reset");
	a_addr_read_zero: assert property ((!cs_n_in && !rd_n_in && addr_in < 11'h008) [*4] |->
		rdata_out[15:13] == 3'h0 && rdata_out[7:5] == 3'h0)
		else $error("unused link address bits read nonzero");
endmodule

/* verification/uopc_atm_model.sv */
// atm layer model that polls utopia phy addresses
`timescale 1ns/100ps
module uopc_atm_model (
	// clock
	input wire clk_in,
	// address the bench wants polled
	input wire [4:0] want_in,
	// address presented to the device
	output reg [4:0] phy_addr_out
);
	// idle on the null address until told otherwise
	initial phy_addr_out = 5'h1F;
	// change just after the edge, then hold for the whole cycle
	always @(posedge clk_in) begin
		phy_addr_out <= #2 want_in;
	end
endmodule

/* verification/uopc_regs_tb.sv */
// self-checking bench for the output port configuration bank
`timescale 1ns/100ps
module uopc_regs_tb;
	reg clk = 1'b0;
	reg rstn = 1'b1;
	reg ce = 1'b1;
	wire rxr;
	wire [79:0] la;
	reg cs_n = 1'b1;
	reg wr_n = 1'b1;
	reg rd_n = 1'b1;
	reg [10:0] addr = 11'h000;
	reg [15:0] wdata = 16'h0000;
	reg [4:0] want = 5'h1F;
	wire [4:0] phy;
	wire [15:0] rdata;
	wire hit;
	wire [3:0] link;
	wire [15:0] en;
	wire b8;
	wire hv;
	wire [7:0] hb;
	integer err_count = 0;
	integer total_checks = 0;
	integer cyc = 0;
	integer i;
	logic [15:0] got;
	logic [10:0] ra;
	logic [15:0] rw;
	logic [15:0] re;
	// offset, word written, word read back
	logic [42:0] rows [0:6] = '{{11'h000, 16'hFFFF, 16'h1F1F}, {11'h007, 16'h0A15, 16'h0A15},
		{11'h010, 16'hA5C3, 16'hA5C3}, {11'h011, 16'h8200, 16'h0200}, {11'h011, 16'h0800, 16'h0800},
		{11'h012, 16'h00C6, 16'h00C6}, {11'h013, 16'h1234, 16'h0000}};
	uopc_atm_model atm (.clk_in(clk), .want_in(want), .phy_addr_out(phy));
	uopc_regs DUT (.core_clk_in(clk), .rstn_in(rstn), .ce_in(ce), .cs_n_in(cs_n), .wr_n_in(wr_n),
		.rd_n_in(rd_n), .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .phy_addr_in(phy),
		.addr_hit_out(hit), .addr_link_out(link), .link_addr_out(la), .link_en_out(en),
		.bus_8bit_out(b8), .rx_sm_reset_out(rxr), .header_byte6_out(hb), .header_byte6_valid_out(hv));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one strobe, held well past the sync delay; read data taken before release
	task automatic acc(input logic w, input logic [10:0] a, input logic [15:0] d);
		@(posedge clk);
		#2;
		addr = a;
		wdata = d;
		cs_n = 1'b0;
		wr_n = !w;
		rd_n = w;
		repeat (6) @(posedge clk);
		#2;
		got = rdata;
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		repeat (4) @(posedge clk);
	endtask
	// present an address and look at the registered decode result
	task automatic poll(input logic [4:0] a, input logic [15:0] exp);
		@(posedge clk);
		#2;
		want = a;
		repeat (8) @(posedge clk);
		#2;
		chk(hit ? {12'h001, link} : 16'h0000, exp);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial forever #10 clk = ~clk;
	// cut a hang short
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			err_count = err_count + 1;
			test_done;
		end
	end
	initial begin
		rstn = 1'b0;
		repeat (20) @(posedge clk);
		#2;
		rstn = 1'b1;
		for (i = 0; i < 7; i = i + 1) begin
			{ra, rw, re} = rows[i];
			acc(1'b1, ra, rw);
			acc(1'b0, ra, 16'h0000);
			chk(got, re);
		end
		chk({b8, hv, 6'h00, hb}, 16'h80C6);
		$display("register rows done");
		@(posedge clk);
		#2;
		rstn = 1'b0;
		repeat (4) @(posedge clk);
		#2;
		rstn = 1'b1;
		for (i = 0; i < 11; i = i + 1) begin
			acc(1'b0, (i < 8) ? i[10:0] : i[10:0] + 11'h008, 16'h0000);
			chk(got, 16'h0000);
		end
		chk({hv, en[14:0]}, 16'h8000);
		$display("reset values done");
		acc(1'b1, 11'h002, 16'h0B03);
		chk({6'h00, la[54:50], la[14:10]}, 16'h0163);
		acc(1'b1, 11'h010, 16'h0404);
		poll(5'h0B, 16'h001A);
		poll(5'h03, 16'h0012);
		poll(5'h05, 16'h0000);
		acc(1'b1, 11'h011, 16'h0200);
		chk({15'h0000, rxr}, 16'h0001);
		poll(5'h03, 16'h0000);
		acc(1'b1, 11'h011, 16'h0000);
		chk({15'h0000, rxr}, 16'h0000);
		poll(5'h03, 16'h0012);
		acc(1'b1, 11'h010, 16'h0400);
		poll(5'h03, 16'h0000);
		$display("address decode done");
		// a strobe made while the clock enable is low must be lost
		@(posedge clk);
		#2;
		ce = 1'b0;
		acc(1'b1, 11'h012, 16'h00AA);
		chk({8'h00, hb}, 16'h0000);
		#2;
		ce = 1'b1;
		acc(1'b0, 11'h012, 16'h0000);
		chk(got, 16'h0000);
		$display("clock enable done");
		test_done;
	end
endmodule
bind uopc_regs uopc_regs_chk u_chk (.core_clk_in, .rstn_in, .ce_in, .cs_n_in, .wr_n_in, .rd_n_in, .addr_in,
	.wdata_in, .rdata_out, .phy_addr_in, .addr_hit_out, .addr_link_out, .link_addr_out, .link_en_out,
	.bus_8bit_out, .rx_sm_reset_out, .header_byte6_out, .header_byte6_valid_out);
